// ===== bench/lin_node_model.sv
// Far-end serial node: drives the receive line and times generated breaks
`timescale 1ns/1ns
`default_nettype none
module lin_node_model (
  // Clock
  input  wire logic pclk,
  // Ticks and line from the device
  input  wire logic rt_tick,
  input  wire logic bit_tick,
  input  wire logic txd,
  // Line to the device, recessive high through the bus pull-up
  output logic      rxd
);
  int low_bits = 0;

  initial rxd = 1'b1;

  // Measured break length, judged by the host and not by the hardware flag
  always @(posedge pclk) begin
    if (txd === 1'b0 && bit_tick === 1'b1) begin
      low_bits <= low_bits + 1;
    end
  end

  task automatic clr();
    low_bits <= 0;
  endtask

  // Dominant level for n sample ticks, then released to the pull-up level
  task automatic hold_low(input int n);
    int i;
    rxd <= 1'b0;
    for (i = 0; i < n; i++) begin
      @(posedge pclk iff rt_tick);
    end
    rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== bench/serial_baud_gen_lin_break_test.sv
// Self-checking bench for the bit rate generator and its LIN break logic
`timescale 1ns/1ns
`default_nettype none
module serial_baud_gen_lin_break_test;
  import baud_gen_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, err;
  logic        rt_tick, bit_tick, break_detected;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [3:0]  pstrb;
  logic [1:0]  osc_div = 2'h0;
  int          failures, check_count, seed, i;

  always #4 pclk = ~pclk;
  // Oscillator source at a quarter of the bus clock, safely below half rate
  always @(posedge pclk) osc_div <= osc_div + 2'h1;

  serial_baud_gen_lin_break dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscillator_clock(osc_div[1]), .rxd(rxd), .txd(txd),
    .rt_tick(rt_tick), .bit_tick(bit_tick), .break_detected(break_detected)
  );

  lin_node_model node_u (
    .pclk(pclk), .rt_tick(rt_tick), .bit_tick(bit_tick), .txd(txd), .rxd(rxd)
  );

  task automatic print_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle cycle so a following call never reassigns psel in this time step
    @(posedge pclk);
  endtask

  function automatic int cdiv(input logic [1:0] c);
    return (c == 2'h0) ? 1 : (c == 2'h1) ? 3 : (c == 2'h2) ? 4 : 13;
  endfunction

  task automatic rate(input logic [1:0] cp, input logic [2:0] sr, input logic [2:0] pd,
                      input logic [4:0] n, input logic src);
    int exp, cyc, rts, bits;
    apb(1'b1, CTRL_OFS, 32'h0, 4'h1);
    apb(1'b1, BRC_OFS, {24'h0, 2'h0, cp, 1'b0, sr}, 4'h1);
    apb(1'b1, FPC_OFS, {24'h0, pd, n}, 4'h1);
    apb(1'b1, CTRL_OFS, {29'h0, 1'b1, 1'b0, src}, 4'h1);
    // Whole fine-adjust frames in 32 sample ticks, so the count is phase free
    exp = 4 * cdiv(cp) * (1 << sr) * ((pd == 3'h0) ? 32 : 32 * (pd + 1) + n) * (src ? 4 : 1);
    cyc = 0;
    while (rt_tick !== 1'b1 && cyc < 40000) begin
      @(posedge pclk);
      cyc++;
    end
    cyc = 0;
    rts = 0;
    bits = 0;
    while (rts < 32 && cyc < 70000) begin
      @(posedge pclk);
      cyc++;
      rts += int'(rt_tick === 1'b1);
      bits += int'(bit_tick === 1'b1);
    end
    chk(cyc, exp);
    chk(bits, 2);
  endtask

  task automatic brk_rx(input logic lin_rx_break_enable, input logic m, input int l);
    apb(1'b1, BRC_OFS, {24'h0, 1'b0, lin_rx_break_enable, 6'h0}, 4'h1);
    apb(1'b1, CTRL_OFS, {29'h0, 1'b1, m, 1'b0}, 4'h1);
    apb(1'b1, STAT_OFS, 32'h1, 4'h1);
    node_u.hold_low(16 * l - 2);
    repeat (8) @(posedge pclk);
    chk(break_detected, 1'b0);
    node_u.hold_low(16 * l + 2);
    repeat (8) @(posedge pclk);
    chk(break_detected, 1'b1);
  endtask

  task automatic brk_tx(input logic lin_tx_break_enable, input logic lin_rx_break_enable, input logic m);
    int c;
    apb(1'b1, BRC_OFS, {24'h0, lin_tx_break_enable, lin_rx_break_enable, 6'h0}, 4'h1);
    node_u.clr();
    apb(1'b1, CTRL_OFS, {28'h0, 1'b1, 1'b1, m, 1'b0}, 4'h1);
    c = 0;
    while (txd !== 1'b0 && c < 200) begin
      @(posedge pclk);
      c++;
    end
    while (txd !== 1'b1 && c < 2000) begin
      @(posedge pclk);
      c++;
    end
    repeat (2) @(posedge pclk);
    chk(node_u.low_bits, (lin_tx_break_enable ? 11 : 10) + m);
  endtask

  initial begin
    #1600000;
    failures++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    seed = 32'h34d287d5;
    failures = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, BRC_OFS, 32'h0, 4'h0);
    chk(rd, 32'h0);
    apb(1'b1, BRC_OFS, 32'hff, 4'h1);
    apb(1'b1, BRC_OFS, 32'h00, 4'h0);
    apb(1'b1, FPC_OFS, 32'hff, 4'h1);
    apb(1'b0, BRC_OFS, 32'h0, 4'h0);
    chk(rd, {24'h0, BRC_WMASK});
    apb(1'b0, 8'h10, 32'h0, 4'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, BRC_OFS, 32'h0, 4'h0);
    chk(rd, 32'h0);
    apb(1'b0, FPC_OFS, 32'h0, 4'h0);
    chk(rd, 32'h0);
    rate(2'h0, 3'h7, 3'h0, 5'h1f, 1'b0);
    rate(2'h3, 3'h0, 3'h7, 5'h1f, 1'b0);
    rate(2'h1, 3'h1, 3'h1, 5'h01, 1'b0);
    rate(2'h0, 3'h0, 3'h1, 5'h01, 1'b1);
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      rate((r[1:0] == 2'h3) ? 2'h2 : r[1:0], {2'h0, r[2]}, r[5:3], r[10:6], 1'b0);
    end
    rate(2'h0, 3'h0, 3'h0, 5'h0, 1'b0);
    for (i = 0; i < 4; i++) begin
      brk_rx(i[1], i[0], 10 + i[1] + i[0]);
    end
    for (i = 0; i < 8; i++) begin
      brk_tx(i[2], i[1], i[0]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== design/baud_gen_pkg.sv
// Register map, field layout, reset values and counts of the bit rate generator
package baud_gen_pkg;

  // Register byte offsets
  localparam logic [7:0] BRC_OFS         = 8'h00;
  localparam logic [7:0] FPC_OFS         = 8'h04;
  localparam logic [7:0] CTRL_OFS        = 8'h08;
  localparam logic [7:0] STAT_OFS        = 8'h0c;

  // bit_rate_control fields
  localparam int         BRC_LIN_TX_BREAK_ENABLE_BIT    = 7;
  localparam int         BRC_LIN_RX_BREAK_ENABLE_BIT    = 6;
  localparam int         BRC_CP_LSB      = 4;
  localparam int         BRC_SR_LSB      = 0;
  localparam logic [7:0] BRC_WMASK       = 8'hf7;

  // fractional_prescale_control fields
  localparam int         FPC_PD_LSB      = 5;
  localparam int         FPC_N_LSB       = 0;

  // Control and status fields
  localparam int         CTRL_SRC_BIT    = 0;
  localparam int         CTRL_M_BIT      = 1;
  localparam int         CTRL_EN_BIT     = 2;
  localparam int         CTRL_BRK_BIT    = 3;
  localparam int         STAT_BKF_BIT    = 0;
  localparam int         STAT_TXB_BIT    = 1;
  localparam int         STAT_RXD_BIT    = 2;

  // Values after reset
  localparam logic [7:0] BRC_RST         = 8'h00;
  localparam logic [7:0] FPC_RST         = 8'h00;
  localparam logic [2:0] CTRL_RST        = 3'h0;

  // Fixed divide by 64 split as 4 ahead of the 16x sample clock, then 16 per bit
  localparam logic [1:0] QUARTER_LAST    = 2'h3;
  localparam logic [3:0] RT_LAST         = 4'hf;
  localparam logic [4:0] FRAC_LAST       = 5'h1f;

  // Break lengths in bit times
  localparam logic [3:0] BRK_BITS_NORM   = 4'ha;
  localparam logic [3:0] BRK_BITS_LIN    = 4'hb;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_WAIT  = 3'b010,
    TX_BREAK = 3'b100
  } txb_state_e;

  // Coarse divisor decode: 1, 3, 4, 13
  function automatic logic [3:0] coarse_div(input logic [1:0] sel);
    case (sel)
      2'h0:    coarse_div = 4'h1;
      2'h1:    coarse_div = 4'h3;
      2'h2:    coarse_div = 4'h4;
      default: coarse_div = 4'hd;
    endcase
  endfunction

  // Power-of-two divisor decode: 1 .. 128
  function automatic logic [7:0] pow2_div(input logic [2:0] sel);
    pow2_div = 8'h01 << sel;
  endfunction

endpackage

// ===== design/serial_baud_gen_lin_break.sv
// Bit rate generator with LIN break detect and break generation, APB register slave
//
// Function
// - Coarse field selects divisor 1,3,4,13
// - Rate select divides by two to field
// - Integer field zero bypasses, else divides field+1
// - Integer bypass also bypasses the fine adjust
// - N extra clocks per 32 prescaler outputs
// - Rate is source over 64*COARSE_DIVISOR*BD*(PD+FRACTIONAL_ADJUST)
// - One rate drives receiver and transmitter
// - LIN receive detects 11 or 12 bit breaks
// - LIN transmit generates 11 or 12 bit breaks
// - RX LIN bit enables detect, TX LIN bit enables generate; detect and generate also run with the bits clear, each bit adds one break bit
// - Zero character up to 10.35 bits is no break; with the RX LIN bit and M clear, a 10 bit dominant run is flagged
// - Reset clears LIN bits and all divider fields
// - Source clock is bus or oscillator clock
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module serial_baud_gen_lin_break
  import baud_gen_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Clock source and serial lines
  input  wire logic              oscillator_clock,
  input  wire logic              rxd,
  output logic                   txd,
  // Rate outputs shared by receiver and transmitter, and the break detect flag
  output logic                   rt_tick,
  output logic                   bit_tick,
  output logic                   break_detected
);

  typedef struct packed {
    logic [7:0]  brc;
    logic [7:0]  fpc;
    logic        src_sel;
    logic        char_len;
    logic        enable;
    logic        bkf;
    logic        osc_q;
    logic [3:0]  ps_cnt;
    logic [4:0]  frac_acc;
    logic        insert;
    logic [3:0]  cp_cnt;
    logic [6:0]  bd_cnt;
    logic [1:0]  q_cnt;
    logic [3:0]  rt_cnt;
    logic [7:0]  rx_low;
    logic        rx_armed;
    txb_state_e  tx_st;
    logic [3:0]  tx_bits;
    logic        txd;
    logic        rt_tick;
    logic        bit_tick;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_s;

  state_s     st_r;
  state_s     st_nxt;

  logic       src_tick;
  logic       ps_tick;
  logic       cp_tick;
  logic       bd_tick;
  logic       rt_fire;
  logic       bit_fire;
  logic       wr_acc;
  logic       brk_req;
  logic [2:0] pd_sel;
  logic [4:0] n_sel;
  logic [3:0] ps_last;
  logic [3:0] brk_bits;
  logic [3:0] tx_brk_bits;
  logic       hi_addr;
  logic [7:0] rx_thresh;
  logic [5:0] frac_sum;
  logic [7:0] addr8;

  assign pd_sel    = st_r.fpc[FPC_PD_LSB +: 3];
  assign n_sel     = st_r.fpc[FPC_N_LSB +: 5];
  assign addr8     = paddr[7:0];

  always_comb begin
    st_nxt    = st_r;
    src_tick  = 1'b0;
    ps_tick   = 1'b0;
    cp_tick   = 1'b0;
    bd_tick   = 1'b0;
    rt_fire   = 1'b0;
    bit_fire  = 1'b0;
    brk_req   = 1'b0;
    frac_sum  = 6'h00;
    wr_acc    = psel & penable & pwrite & st_r.pready & ~st_r.pslverr & pstrb[0];
    ps_last   = 4'({1'b0, pd_sel} + {3'h0, st_r.insert});
    // Break length: LIN adds one bit, long characters add one more
    brk_bits  = (st_r.brc[BRC_LIN_RX_BREAK_ENABLE_BIT] ? BRK_BITS_LIN : BRK_BITS_NORM) + {3'h0, st_r.char_len};
    rx_thresh = {brk_bits, 4'h0};
    // Generated break length follows the transmit LIN bit
    tx_brk_bits = (st_r.brc[BRC_LIN_TX_BREAK_ENABLE_BIT] ? BRK_BITS_LIN : BRK_BITS_NORM) + {3'h0, st_r.char_len};
    // Address bits above the register window flag an error; empty when ADDR_W is 8
    hi_addr   = ((paddr >> 8) != '0);

    // Oscillator is sampled on the bus clock, so it must run below half of it
    st_nxt.osc_q = oscillator_clock;
    if (st_r.enable) begin
      src_tick = st_r.src_sel ? (oscillator_clock & ~st_r.osc_q) : 1'b1;
    end

    // Integer prescaler with fractional insertion
    if (pd_sel == 3'h0) begin
      ps_tick = src_tick;
      st_nxt.ps_cnt   = 4'h0;
      st_nxt.frac_acc = 5'h00;
      st_nxt.insert   = 1'b0;
    end else if (src_tick) begin
      if (st_r.ps_cnt == ps_last) begin
        ps_tick         = 1'b1;
        st_nxt.ps_cnt   = 4'h0;
        // Accumulator carry spreads N stretches evenly over 32 outputs
        frac_sum        = {1'b0, st_r.frac_acc} + {1'b0, n_sel};
        st_nxt.frac_acc = frac_sum[4:0];
        st_nxt.insert   = frac_sum[5];
      end else begin
        st_nxt.ps_cnt = st_r.ps_cnt + 4'h1;
      end
    end

    // Coarse divisor
    if (ps_tick) begin
      if (st_r.cp_cnt >= coarse_div(st_r.brc[BRC_CP_LSB +: 2]) - 4'h1) begin
        cp_tick       = 1'b1;
        st_nxt.cp_cnt = 4'h0;
      end else begin
        st_nxt.cp_cnt = st_r.cp_cnt + 4'h1;
      end
    end

    // Power-of-two divisor
    if (cp_tick) begin
      if ({1'b0, st_r.bd_cnt} >= pow2_div(st_r.brc[BRC_SR_LSB +: 3]) - 8'h01) begin
        bd_tick       = 1'b1;
        st_nxt.bd_cnt = 7'h00;
      end else begin
        st_nxt.bd_cnt = st_r.bd_cnt + 7'h01;
      end
    end

    // Fixed divide by 4 then by 16 gives the total factor of 64
    if (bd_tick) begin
      st_nxt.q_cnt = st_r.q_cnt + 2'h1;
      rt_fire      = (st_r.q_cnt == QUARTER_LAST);
    end
    if (rt_fire) begin
      st_nxt.rt_cnt = st_r.rt_cnt + 4'h1;
      bit_fire      = (st_r.rt_cnt == RT_LAST);
    end
    st_nxt.rt_tick  = rt_fire;
    st_nxt.bit_tick = bit_fire;

    // Disabled module holds the whole chain in its start position
    if (!st_r.enable) begin
      st_nxt.ps_cnt   = 4'h0;
      st_nxt.frac_acc = 5'h00;
      st_nxt.insert   = 1'b0;
      st_nxt.cp_cnt   = 4'h0;
      st_nxt.bd_cnt   = 7'h00;
      st_nxt.q_cnt    = 2'h0;
      st_nxt.rt_cnt   = 4'h0;
    end

    // Break detect: count dominant 16x samples, rearm only after a recessive level
    if (rxd) begin
      st_nxt.rx_low   = 8'h00;
      st_nxt.rx_armed = 1'b1;
    end else if (rt_fire) begin
      if (st_r.rx_low != 8'hff) begin
        st_nxt.rx_low = st_r.rx_low + 8'h01;
      end
    end

    // APB access phase
    if (psel && penable && st_r.pready) begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (wr_acc) begin
        case (addr8)
          BRC_OFS: begin
            st_nxt.brc = pwdata[7:0] & BRC_WMASK;
          end
          FPC_OFS: begin
            st_nxt.fpc = pwdata[7:0];
          end
          CTRL_OFS: begin
            st_nxt.src_sel  = pwdata[CTRL_SRC_BIT];
            st_nxt.char_len = pwdata[CTRL_M_BIT];
            st_nxt.enable   = pwdata[CTRL_EN_BIT];
            brk_req         = pwdata[CTRL_BRK_BIT];
          end
          STAT_OFS: begin
            if (pwdata[STAT_BKF_BIT]) begin
              st_nxt.bkf = 1'b0;
            end
          end
          default: begin
            st_nxt.bkf = st_r.bkf;
          end
        endcase
      end
    end else if (psel && !penable) begin
      // Setup phase: answer is prepared for a one-cycle access phase
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata  = 32'h0000_0000;
      case (addr8)
        BRC_OFS: begin
          st_nxt.prdata[7:0] = st_r.brc;
        end
        FPC_OFS: begin
          st_nxt.prdata[7:0] = st_r.fpc;
        end
        CTRL_OFS: begin
          st_nxt.prdata[2:0] = {st_r.enable, st_r.char_len, st_r.src_sel};
        end
        STAT_OFS: begin
          st_nxt.prdata[2:0] = {rxd, (st_r.tx_st != TX_IDLE), st_r.bkf};
        end
        default: begin
          st_nxt.pslverr = 1'b1;
        end
      endcase
      if (hi_addr) begin
        st_nxt.pslverr = 1'b1;
        st_nxt.prdata  = 32'h0000_0000;
      end
    end

    // Set wins over a clear in the same cycle
    if (rt_fire && !rxd && st_r.rx_armed && st_r.rx_low == rx_thresh - 8'h01) begin
      st_nxt.bkf      = 1'b1;
      st_nxt.rx_armed = 1'b0;
    end

    // Break generation; waits for a bit boundary so every bit is whole
    case (st_r.tx_st)
      TX_IDLE: begin
        st_nxt.txd = 1'b1;
        if (brk_req && st_r.enable) begin
          st_nxt.tx_st = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (!st_r.enable) begin
          st_nxt.tx_st = TX_IDLE;
        end else if (bit_fire) begin
          st_nxt.tx_st   = TX_BREAK;
          st_nxt.txd     = 1'b0;
          st_nxt.tx_bits = 4'h0;
        end
      end
      TX_BREAK: begin
        if (!st_r.enable) begin
          st_nxt.tx_st = TX_IDLE;
          st_nxt.txd   = 1'b1;
        end else if (bit_fire) begin
          st_nxt.tx_bits = st_r.tx_bits + 4'h1;
          if (st_r.tx_bits == tx_brk_bits - 4'h1) begin
            st_nxt.tx_st = TX_IDLE;
            st_nxt.txd   = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.tx_st = TX_IDLE;
        st_nxt.txd   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.brc      <= BRC_RST;
      st_r.fpc      <= FPC_RST;
      st_r.tx_st    <= TX_IDLE;
      st_r.txd      <= 1'b1;
      st_r.rx_armed <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata         = st_r.prdata;
  assign pready         = st_r.pready;
  assign pslverr        = st_r.pslverr;
  assign txd            = st_r.txd;
  assign rt_tick        = st_r.rt_tick;
  assign bit_tick       = st_r.bit_tick;
  assign break_detected = st_r.bkf;

  // Helper counters that measure each divider stage independently
  logic [3:0] hc_ps_gap;
  logic [3:0] hc_cp_gap;
  logic [7:0] hc_bd_gap;
  logic [4:0] hc_frm;
  logic [5:0] hc_ins;
  logic [2:0] hc_valid;
  logic       hc_frm_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc_ps_gap <= 4'h0;
      hc_cp_gap <= 4'h0;
      hc_bd_gap <= 8'h00;
      hc_frm    <= 5'h00;
      hc_ins    <= 6'h00;
      hc_valid  <= 3'h0;
      hc_frm_ok <= 1'b0;
    end else if (wr_acc || !st_r.enable) begin
      hc_valid  <= 3'h0;
      hc_frm_ok <= 1'b0;
      hc_frm    <= 5'h00;
      hc_ins    <= 6'h00;
    end else begin
      if (src_tick) begin
        hc_ps_gap <= ps_tick ? 4'h0 : hc_ps_gap + 4'h1;
      end
      if (ps_tick) begin
        hc_cp_gap   <= cp_tick ? 4'h0 : hc_cp_gap + 4'h1;
        hc_valid[0] <= 1'b1;
        hc_frm      <= hc_frm + 5'h01;
        hc_ins      <= (hc_frm == FRAC_LAST) ? 6'h00 : hc_ins + {5'h00, st_r.insert};
        if (hc_frm == FRAC_LAST) begin
          hc_frm_ok <= 1'b1;
        end
      end
      if (cp_tick) begin
        hc_bd_gap   <= bd_tick ? 8'h00 : hc_bd_gap + 8'h01;
        hc_valid[1] <= 1'b1;
      end
      if (bd_tick) begin
        hc_valid[2] <= 1'b1;
      end
    end
  end

  AST_RESET_CLEAR: assert property (@(posedge pclk) $rose(presetn) |->
    (st_r.brc == BRC_RST && st_r.fpc == FPC_RST && !st_r.bkf))
    else $error("Registers not cleared by reset");

  AST_INT_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
    (ps_tick && hc_valid[0] && pd_sel != 3'h0 && !wr_acc) |->
    (hc_ps_gap == 4'({1'b0, pd_sel} + {3'h0, st_r.insert})))
    else $error("Integer prescaler period wrong");

  AST_BYPASS: assert property (@(posedge pclk) disable iff (!presetn)
    (pd_sel == 3'h0) |-> (ps_tick == src_tick && !st_nxt.insert))
    else $error("Bypass does not pass the source clock");

  AST_FRAC_FRAME: assert property (@(posedge pclk) disable iff (!presetn)
    (ps_tick && hc_frm_ok && hc_frm == FRAC_LAST && pd_sel != 3'h0 && !wr_acc) |->
    (hc_ins + {5'h00, st_r.insert} == {1'b0, n_sel}))
    else $error("Inserted clocks per frame differ from N");

  AST_COARSE: assert property (@(posedge pclk) disable iff (!presetn)
    (cp_tick && hc_valid[1] && !wr_acc) |->
    (hc_cp_gap == coarse_div(st_r.brc[BRC_CP_LSB +: 2]) - 4'h1))
    else $error("Coarse divisor wrong");

  AST_POW2: assert property (@(posedge pclk) disable iff (!presetn)
    (bd_tick && hc_valid[2] && !wr_acc) |->
    (hc_bd_gap == pow2_div(st_r.brc[BRC_SR_LSB +: 3]) - 8'h01))
    else $error("Power-of-two divisor wrong");

  AST_BIT_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    (rt_tick && st_r.rt_cnt == 4'h0 && st_r.enable) |-> bit_tick)
    else $error("Bit tick not after sixteen sample ticks");

  AST_RX_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r.bkf) |-> ($past(rxd) == 1'b0 && st_r.rx_low == rx_thresh))
    else $error("Break flagged at wrong dominant length");

  AST_NO_SHORT_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(st_r.bkf) && st_r.brc[BRC_LIN_RX_BREAK_ENABLE_BIT]) |-> (st_r.rx_low > 8'ha5))
    else $error("Break flagged for a short dominant run");

  AST_TX_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.tx_st == TX_BREAK && bit_fire && st_r.tx_bits == tx_brk_bits - 4'h1 && st_r.enable) |=>
    (st_r.txd && st_r.tx_st == TX_IDLE && $past(st_r.txd) == 1'b0))
    else $error("Transmit break length wrong");

endmodule
`default_nettype wire
